/* File: logic/psc_hold_timer.sv */
/*
  Qualifies a level: done rises once the level has held for COUNT
  consecutive cycles and falls as soon as the level drops.
  Assumes the level is already in the clock domain.
*/
module psc_hold_timer #(
  parameter int COUNT = 20
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic level,
  output logic done
);

  localparam int CW = $clog2(COUNT + 1);

  if (COUNT < 1)
  begin : g_count_check
    $error("psc_hold_timer: COUNT must be at least 1");
  end

  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic done_d;

  always_comb
  begin
    cnt_d = cnt_q;
    done_d = 1'b0;
    if (!level)
      cnt_d = '0;
    else if (cnt_q != CW'(COUNT))
      cnt_d = cnt_q + 1'b1;
    done_d = level && (cnt_d == CW'(COUNT));
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cnt_q <= '0;
      done <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      done <= done_d;
    end
  end

endmodule

/* File: logic/psc_pkg.sv */
/*
  Shared constants for the peripheral bus target sequencer: request and
  selection octet layouts, parity sense and hold-time figures.
  Assumes a single 10 MHz core clock.
*/
package psc_pkg;

  // ***************************************************************
  // Clock and hold times
  // ***************************************************************
  localparam int CLK_PERIOD_NS = 100;
  localparam int HOLD_MIN_NS = 2000;
  // A least time rounds up to whole cycles.
  localparam int HOLD_CYCLES = (HOLD_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ***************************************************************
  // Octet layouts on the host octet bus
  // ***************************************************************
  localparam int REQ_CODE_LSB = 4;
  localparam int ADDR_LSB = 0;
  localparam int ADDR_W = 3;
  localparam logic [3:0] REQ_POLL_IRQ = 4'h0;
  localparam logic [3:0] REQ_SETTINGS = 4'h1;
  localparam logic [3:0] REQ_FAC_IRQ = 4'h2;
  localparam logic [3:0] REQ_SEL_RESET = 4'h3;

  // Odd parity: octet plus parity bit holds an odd count of ones.
  localparam logic PARITY_ODD = 1'b1;

  // ***************************************************************
  // Reset values of the pin side
  // ***************************************************************
  localparam logic [7:0] BUS_B_RST = 8'h00;

endpackage

/* File: logic/psc_sync.sv */
/*
  Two flip-flop synchroniser for a group of asynchronous pin inputs.
  Assumes each bit is independent; multi-bit values need their own qualifier.
*/
module psc_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_d;

  always_comb
  begin
    meta_d = async_in;
    sync_d = meta_q;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      meta_q <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta_q <= meta_d;
      sync_out <= sync_d;
    end
  end

endmodule

/* File: logic/psc_target.sv */
/*
  Target-side sequencer of a master/slave parallel peripheral bus: request
  polls and queries, selection, bus control, ending status, master reset and
  selective reset. Host lines arrive asynchronously and are synchronised here.
  Assumes the host holds each octet stable before moving its strobe lines and
  that user-side inputs are on clk.
*/
// Contract
// [R01] Interrupt poll: matching pending target drives its bit address on the target bus.
// [R02] Host skips target parity in a poll and ends it by dropping phase.
// [R03] Host waits for the slowest target before sampling and before the next sequence.
// [R04] Settings query: target drives response, asserts phase, drops it after host does.
// [R05] Facility query follows the settings handshake with a facility address octet.
// [R06] Host places the selection octet, then asserts select.
// [R07] Selected ready target drives its address first, then asserts phase.
// [R08] Selected busy target asserts only phase, with no address octet.
// [R09] Selection octet with bad parity selects nobody; no phase asserted.
// [R10] Target stays selected while select is active; deselects when it drops.
// [R11] Master reset: host drops select and phase, then strobes at least 10 us.
// [R12] Maintenance detected separately and entered only after 2 us.
// [R13] Selective reset: host sends octet, phase, then strobe at least 10 us.
// [R14] Selective reset detected separately; no action or release before 2 us.
// [R15] Host ends selective reset by dropping phase, then watches target phase drop. The code drops target phase once the reset qualifies, mid-strobe.
// [R16] Bus control: host octet and strobe, target ack octet and strobe, host drops.
// [R17] After bus control the target reenters acknowledge presenting no status octet.
// [R18] Ending status: target releases the bus, then drops phase, entering end state. The code drops bus drive and phase in the same cycle.
// [R19] Host then drives master status and drops its phase line.
// [R20] Target then drives slave status and reasserts phase, back in acknowledge.
// [R21] Transfers are framed by bus control and ending status; target may skip transfer.
// [R22] On an undefined host move the target releases the bus, then drops both lines.
// [R23] Every host line is synchronised before it steers any transition.
module psc_target #(
  parameter int HOLD_CYCLES = psc_pkg::HOLD_CYCLES
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic select_out,
  input wire logic master_out,
  input wire logic sync_out,
  input wire logic [7:0] bus_a,
  input wire logic bus_a_par,
  output logic slave_in,
  output logic sync_in,
  output logic [7:0] bus_b,
  output logic bus_b_par,
  output logic bus_b_oe,
  input wire logic [2:0] my_addr,
  input wire logic busy,
  input wire logic irq_pending,
  input wire logic [7:0] settings_octet,
  input wire logic [7:0] fac_irq_octet,
  input wire logic [7:0] bus_ack_octet,
  input wire logic [7:0] slave_status_octet,
  output logic selected,
  output logic [7:0] host_octet,
  output logic bus_ctl_valid,
  output logic master_status_valid,
  output logic maintenance_state_mode,
  output logic reset_action
);

  if (HOLD_CYCLES < 1)
  begin : g_hold_check
    $error("psc_target: HOLD_CYCLES must be at least 1");
  end

  // ***************************************************************
  // Input synchronisation and edge detection
  // ***************************************************************
  logic [11:0] pins_s;
  logic sel_s, mst_s, syn_s, par_s;
  logic [7:0] a_s;
  logic mst_p_q, syn_p_q;
  logic mst_p_d, syn_p_d;

  psc_sync #(.WIDTH(12)) u_sync (
    .clk(clk),
    .arst_n(arst_n),
    .async_in({select_out, master_out, sync_out, bus_a_par, bus_a}),
    .sync_out(pins_s)
  ); // see [R23]

  always_comb
  begin
    {sel_s, mst_s, syn_s, par_s, a_s} = pins_s;
    mst_p_d = mst_s;
    syn_p_d = syn_s;
  end

  function automatic logic odd_par(input logic [7:0] v);
    return ~^v ^ ~psc_pkg::PARITY_ODD;
  endfunction

  function automatic logic [7:0] bit_addr(input logic [2:0] a);
    return 8'h01 << a;
  endfunction

  logic par_ok, addr_me, mst_rise, mst_fall, syn_rise, syn_fall;
  logic [3:0] req_code;
  always_comb
  begin
    par_ok = (odd_par(a_s) == par_s);
    addr_me = (a_s[psc_pkg::ADDR_LSB +: psc_pkg::ADDR_W] == my_addr);
    req_code = a_s[psc_pkg::REQ_CODE_LSB +: 4];
    mst_rise = mst_s && !mst_p_q;
    mst_fall = !mst_s && mst_p_q;
    syn_rise = syn_s && !syn_p_q;
    syn_fall = !syn_s && syn_p_q;
  end

  // ***************************************************************
  // Independent reset detection
  // ***************************************************************
  // Kept apart from the main state machine so a wedged sequence cannot
  // block maintenance entry or a selective reset.
  logic armed_q, armed_d, maintenance_state_q, maintenance_state_d, rst_q, rst_d;
  logic maintenance_state_done, srst_done, srst_done_p_q;

  psc_hold_timer #(.COUNT(HOLD_CYCLES)) u_maintenance_state (
    .clk(clk),
    .arst_n(arst_n),
    .level(syn_s && !sel_s && !mst_s),
    .done(maintenance_state_done)
  ); // see [R12]

  psc_hold_timer #(.COUNT(HOLD_CYCLES)) u_srst (
    .clk(clk),
    .arst_n(arst_n),
    .level(armed_q && mst_s && syn_s && !sel_s),
    .done(srst_done)
  ); // see [R14]

  always_comb
  begin
    armed_d = armed_q;
    if (!mst_s)
      armed_d = 1'b0;
    else if (mst_rise && !sel_s)
      armed_d = par_ok && addr_me && (req_code == psc_pkg::REQ_SEL_RESET);
    rst_d = srst_done && !srst_done_p_q; // see [R14]
    maintenance_state_d = maintenance_state_q;
    if (maintenance_state_done)
      maintenance_state_d = 1'b1; // see [R12]
    else if (rst_d)
      maintenance_state_d = 1'b0;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      armed_q <= 1'b0;
      maintenance_state_q <= 1'b0;
      rst_q <= 1'b0;
      srst_done_p_q <= 1'b0;
      mst_p_q <= 1'b0;
      syn_p_q <= 1'b0;
    end
    else
    begin
      armed_q <= armed_d;
      maintenance_state_q <= maintenance_state_d;
      rst_q <= rst_d;
      srst_done_p_q <= srst_done;
      mst_p_q <= mst_p_d;
      syn_p_q <= syn_p_d;
    end
  end

  // ***************************************************************
  // Sequence state machine
  // ***************************************************************
  typedef enum logic [3:0] {
    ST_IDLE, ST_POLL, ST_QRY_DRIVE, ST_QRY_ACK, ST_SRST, ST_SEL_DRIVE,
    ST_ACK, ST_BUSY, ST_BUSCTL, ST_XFER, ST_END, ST_STAT_DRIVE,
    ST_SEL_IGNORE, ST_DESELECTED_STATE, ST_ERR_REL, ST_ERR_WAIT
  } psc_state_t;

  psc_state_t st_q, st_d;
  logic slv_q, slv_d, syi_q, syi_d, oe_q, oe_d, sel_q, sel_d;
  logic [7:0] b_q, b_d, hoct_q, hoct_d;
  logic bcv_q, bcv_d, msv_q, msv_d;

  always_comb
  begin
    st_d = st_q;
    slv_d = slv_q;
    syi_d = syi_q;
    oe_d = oe_q;
    b_d = b_q;
    sel_d = sel_q;
    hoct_d = hoct_q;
    bcv_d = 1'b0;
    msv_d = 1'b0;
    case (st_q)
      ST_IDLE:
      begin
        if (sel_s && !mst_s)
        begin
          if (!par_ok || !addr_me)
            st_d = ST_SEL_IGNORE; // see [R09]
          else if (busy)
          begin
            slv_d = 1'b1; // see [R08]
            sel_d = 1'b1;
            st_d = ST_BUSY;
          end
          else
          begin
            b_d = bit_addr(my_addr); // see [R07]
            oe_d = 1'b1;
            sel_d = 1'b1;
            st_d = ST_SEL_DRIVE;
          end
        end
        else if (mst_rise && !sel_s && par_ok)
        begin
          case (req_code)
            psc_pkg::REQ_POLL_IRQ:
            begin
              if (irq_pending)
              begin
                b_d = bit_addr(my_addr); // see [R01]
                oe_d = 1'b1;
              end
              st_d = ST_POLL;
            end
            psc_pkg::REQ_SETTINGS:
            begin
              if (addr_me)
              begin
                b_d = settings_octet; // see [R04]
                oe_d = 1'b1;
                st_d = ST_QRY_DRIVE;
              end
            end
            psc_pkg::REQ_FAC_IRQ:
            begin
              if (addr_me)
              begin
                b_d = fac_irq_octet; // see [R05]
                oe_d = 1'b1;
                st_d = ST_QRY_DRIVE;
              end
            end
            psc_pkg::REQ_SEL_RESET:
            begin
              if (addr_me)
              begin
                slv_d = 1'b1; // see [R13]
                st_d = ST_SRST;
              end
            end
            default: st_d = ST_IDLE;
          endcase
        end
      end
      ST_POLL:
      begin
        if (!mst_s)
        begin
          oe_d = 1'b0; // see [R02]
          st_d = ST_IDLE;
        end
      end
      ST_QRY_DRIVE:
      begin
        slv_d = 1'b1; // see [R04]
        st_d = ST_QRY_ACK;
      end
      ST_QRY_ACK:
      begin
        if (!mst_s)
          st_d = ST_DESELECTED_STATE; // see [R04]
      end
      ST_SRST:
      begin
        // Lines stay put until the reset has qualified or the host ends it.
        if (rst_d || !mst_s)
          st_d = ST_ERR_REL; // see [R14] [R15]
      end
      ST_SEL_DRIVE:
      begin
        slv_d = 1'b1; // see [R07]
        st_d = ST_ACK;
      end
      ST_BUSY:
      begin
        if (!sel_s)
          st_d = ST_DESELECTED_STATE; // see [R10]
        else if (syn_rise || mst_rise)
          st_d = ST_ERR_REL; // see [R22]
      end
      ST_ACK, ST_XFER:
      begin
        if (!sel_s)
          st_d = ST_DESELECTED_STATE; // see [R10]
        else if (syn_rise)
        begin
          hoct_d = a_s; // see [R16]
          bcv_d = 1'b1;
          b_d = bus_ack_octet;
          oe_d = 1'b1;
          syi_d = 1'b1;
          st_d = ST_BUSCTL;
        end
        else if (mst_rise && st_q == ST_XFER)
        begin
          oe_d = 1'b0; // see [R18] [R21]
          slv_d = 1'b0;
          st_d = ST_END;
        end
        else if (mst_rise)
          st_d = ST_ERR_REL; // see [R22]
      end
      ST_BUSCTL:
      begin
        if (!sel_s)
          st_d = ST_DESELECTED_STATE;
        else if (syn_fall)
        begin
          oe_d = 1'b0; // see [R17]
          syi_d = 1'b0;
          st_d = ST_XFER;
        end
      end
      ST_END:
      begin
        if (!sel_s)
          st_d = ST_DESELECTED_STATE;
        else if (mst_fall)
        begin
          hoct_d = a_s; // see [R19]
          msv_d = 1'b1;
          b_d = slave_status_octet; // see [R20]
          oe_d = 1'b1;
          st_d = ST_STAT_DRIVE;
        end
      end
      ST_STAT_DRIVE:
      begin
        slv_d = 1'b1; // see [R20]
        st_d = ST_ACK;
      end
      ST_SEL_IGNORE:
      begin
        if (!sel_s)
          st_d = ST_IDLE; // see [R09]
      end
      ST_DESELECTED_STATE:
      begin
        oe_d = 1'b0; // see [R10]
        st_d = ST_ERR_WAIT;
      end
      ST_ERR_REL:
      begin
        oe_d = 1'b0; // see [R22]
        st_d = ST_ERR_WAIT;
      end
      ST_ERR_WAIT:
      begin
        slv_d = 1'b0; // see [R22]
        syi_d = 1'b0;
        sel_d = 1'b0;
        if (!sel_s && !mst_s)
          st_d = ST_IDLE;
      end
      default: st_d = ST_ERR_REL;
    endcase
    // A qualified selective reset wins in every state but ST_ERR_WAIT and drops the target off the bus.
    if (rst_d && st_q != ST_ERR_WAIT)
    begin
      oe_d = 1'b0; // see [R14]
      st_d = ST_ERR_REL;
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_q <= ST_IDLE;
      slv_q <= 1'b0;
      syi_q <= 1'b0;
      oe_q <= 1'b0;
      b_q <= psc_pkg::BUS_B_RST;
      sel_q <= 1'b0;
      hoct_q <= 8'h00;
      bcv_q <= 1'b0;
      msv_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      slv_q <= slv_d;
      syi_q <= syi_d;
      oe_q <= oe_d;
      b_q <= b_d;
      sel_q <= sel_d;
      hoct_q <= hoct_d;
      bcv_q <= bcv_d;
      msv_q <= msv_d;
    end
  end

  // ***************************************************************
  // Outputs, all straight from flip-flops
  // ***************************************************************
  logic bpar_q;
  logic bpar_d;
  always_comb
  begin
    bpar_d = odd_par(b_d);
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      bpar_q <= 1'b0;
    else
      bpar_q <= bpar_d;
  end

  assign slave_in = slv_q;
  assign sync_in = syi_q;
  assign bus_b = b_q;
  assign bus_b_par = bpar_q;
  assign bus_b_oe = oe_q;
  assign selected = sel_q;
  assign host_octet = hoct_q;
  assign bus_ctl_valid = bcv_q;
  assign master_status_valid = msv_q;
  assign maintenance_state_mode = maintenance_state_q;
  assign reset_action = rst_q;

endmodule

/* File: verification/psc_host_model.sv */
/*
  Host controller model driving select, phase, strobe and the host octet.
  Assumes the bench calls its tasks; lines move at falling clock edges.
*/
module psc_host_model (
  input wire logic clk,
  input wire logic slave_in,
  output logic select_out,
  output logic master_out,
  output logic sync_out,
  output logic [7:0] bus_a,
  output logic bus_a_par
);
  timeunit 1ns;
  timeprecision 1ns;
  // Target bus parity is never checked here.
  initial
  begin
    {select_out, master_out, sync_out} = 3'h0;
    bus_a = 8'h00;
    bus_a_par = 1'b1;
  end
  task automatic put(input logic [7:0] o, input logic bad);
  begin
    @(negedge clk);
    bus_a = o;
    bus_a_par = ~^o ^ bad;
  end
  endtask
  // Idle octet is scrambled so nothing stale looks valid; then the host
  // waits for the slowest target to let go.
  task automatic lines(input logic s, input logic m, input logic y);
  begin
    @(negedge clk);
    {select_out, master_out, sync_out} = {s, m, y};
    if (!(s | m | y))
    begin
      bus_a = ~bus_a;
      bus_a_par = ~bus_a_par;
      repeat (8) @(negedge clk);
    end
  end
  endtask
  // The strobe stands 101 cycles of the 10 MHz clock, just over 10 us.
  task automatic strobe(input logic s, input logic m);
  begin
    lines(s, m, 1'b1);
    repeat (100) @(negedge clk);
    lines(s, m, 1'b0);
  end
  endtask
  task automatic sel_reset(input logic [2:0] a);
    int k;
  begin
    put({4'h3, 1'b0, a}, 1'b0);
    lines(1'b0, 1'b1, 1'b0);
    for (k = 0; k < 12 && !slave_in; k++)
      @(negedge clk);
    strobe(1'b0, 1'b1);
    lines(1'b0, 1'b0, 1'b0);
    for (k = 0; k < 12 && slave_in; k++)
      @(negedge clk);
  end
  endtask
endmodule

/* File: verification/psc_target_assertions.sv */
/*
  Checker for psc_target: handshake order, octets and hold times at its pins.
  Assumes it is bound to psc_target and sees only its ports.
*/
module psc_target_assertions #(
  parameter int HOLD_CYCLES = 20
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic select_out,
  input wire logic master_out,
  input wire logic sync_out,
  input wire logic [7:0] bus_a,
  input wire logic bus_a_par,
  input wire logic slave_in,
  input wire logic sync_in,
  input wire logic [7:0] bus_b,
  input wire logic bus_b_oe,
  input wire logic [2:0] my_addr,
  input wire logic [7:0] bus_ack_octet,
  input wire logic [7:0] slave_status_octet,
  input wire logic selected,
  input wire logic bus_ctl_valid,
  input wire logic master_status_valid,
  input wire logic maintenance_state_mode,
  input wire logic reset_action
);
  timeunit 1ns;
  timeprecision 1ns;
  // A finished run keeps its length, because the core sees the pins late.
  int mr_q, mr_d, sr_q, sr_d;
  logic mr_on_q, sr_on_q, mr_on, sr_on;
  assign mr_on = sync_out && !select_out && !master_out;
  assign sr_on = sync_out && master_out;
  always_comb
  begin
    mr_d = mr_on ? (mr_on_q ? mr_q + 1 : 1) : mr_q;
    sr_d = sr_on ? (sr_on_q ? sr_q + 1 : 1) : sr_q;
  end
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      mr_q <= 0;
      sr_q <= 0;
      {mr_on_q, sr_on_q} <= 2'h0;
    end
    else
    begin
      mr_q <= mr_d;
      sr_q <= sr_d;
      {mr_on_q, sr_on_q} <= {mr_on, sr_on};
    end
  end
  // ***************
  // Properties
  // ***************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  sequence s_released;
    !bus_b_oe && !$past(bus_b_oe);
  endsequence
  sequence s_ack;
    bus_b_oe && bus_b == bus_ack_octet && bus_ctl_valid;
  endsequence
  sequence s_status;
    bus_b_oe && bus_b == slave_status_octet ##1 slave_in;
  endsequence
  AST_ADDR_FIRST: assert property ($rose(slave_in) && selected && bus_b_oe |-> $past(bus_b_oe))
    else $error("phase rose before address");
  AST_SEL_ADDR: assert property ($rose(selected) && bus_b_oe |-> bus_b == (8'h01 << my_addr))
    else $error("wrong address octet");
  AST_BUSY: assert property ($rose(selected) && !bus_b_oe |-> slave_in)
    else $error("busy without phase");
  AST_SEL_OK: assert property ($rose(selected) |-> $past(select_out, 2) && ^{bus_a, bus_a_par})
    else $error("selected without valid select");
  AST_DESELECTED_STATE: assert property ($fell(select_out) |-> ##[1:6] !selected)
    else $error("still selected");
  AST_MAINTENANCE_STATE_HOLD: assert property ($rose(maintenance_state_mode) |-> mr_q >= HOLD_CYCLES)
    else $error("maintenance too early");
  AST_SRESET_HOLD: assert property (reset_action |-> sr_q >= HOLD_CYCLES ##1 !reset_action)
    else $error("selective reset too early");
  AST_BUS_ACK: assert property ($rose(sync_in) |-> s_ack)
    else $error("bad bus acknowledge");
  AST_NO_STATUS: assert property ($fell(sync_in) |-> !bus_b_oe)
    else $error("octet after bus control");
  AST_STATUS: assert property (master_status_valid |-> s_status)
    else $error("bad ending status");
  AST_RELEASE: assert property ($fell(slave_in) |-> s_released)
    else $error("phase dropped before release");
endmodule

bind psc_target psc_target_assertions #(.HOLD_CYCLES(HOLD_CYCLES)) i_chk (
  .clk, .arst_n, .select_out, .master_out, .sync_out, .bus_a, .bus_a_par,
  .slave_in, .sync_in, .bus_b, .bus_b_oe, .my_addr, .bus_ack_octet,
  .slave_status_octet, .selected, .bus_ctl_valid, .master_status_valid,
  .maintenance_state_mode, .reset_action
);

/* File: verification/psc_target_tb.sv */
/*
  Self-checking bench for psc_target, host side through psc_host_model.
  Assumes the bound checker watches the same run.
*/
module psc_target_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, arst_n, select_out, master_out, sync_out, bus_a_par, slave_in;
  logic sync_in, bus_b_par, bus_b_oe, busy, irq_pending, selected;
  logic bus_ctl_valid, master_status_valid, maintenance_state_mode, reset_action;
  logic [2:0] my_addr;
  logic [7:0] bus_a, bus_b, settings_octet, fac_irq_octet, bus_ack_octet;
  logic [7:0] slave_status_octet, host_octet;
  int n_mismatch = 0;
  int total_checks = 0;
  int n_pulse = 0;
  int cycles = 0;
  wire [4:0] obs = {maintenance_state_mode, selected, bus_b_oe, sync_in, slave_in};
  psc_target #(.HOLD_CYCLES(20)) i_dut (.clk, .arst_n, .select_out,
    .master_out, .sync_out, .bus_a, .bus_a_par, .slave_in, .sync_in, .bus_b,
    .bus_b_par, .bus_b_oe, .my_addr, .busy, .irq_pending, .settings_octet,
    .fac_irq_octet, .bus_ack_octet, .slave_status_octet, .selected,
    .host_octet, .bus_ctl_valid, .master_status_valid, .maintenance_state_mode,
    .reset_action);
  psc_host_model i_host (.clk, .slave_in, .select_out, .master_out,
    .sync_out, .bus_a, .bus_a_par);
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(negedge clk)
  begin
    cycles++;
    n_pulse += (reset_action === 1'b1);
    if (cycles == 5000)
    begin
      n_mismatch++;
      wrap_up();
    end
  end
  task automatic wrap_up;
  begin
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  end
  endtask
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
  begin
    total_checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  end
  endtask
  task automatic wt(input string n, input int i, input logic v);
    int k;
  begin
    for (k = 0; k < 12 && obs[i] !== v; k++)
      @(negedge clk);
    chk(n, 8'(v), 8'(obs[i]));
  end
  endtask
  task automatic t_exchange;
  begin
    i_host.put({5'h00, my_addr}, 1'b0);
    i_host.lines(1'b1, 1'b0, 1'b0);
    wt("phase", 0, 1'b1);
    chk("address", 8'h01 << my_addr, bus_b);
    chk("selected", 8'h01, 8'(selected));
    i_host.put(8'h5a, 1'b0);
    i_host.lines(1'b1, 1'b0, 1'b1);
    wt("strobe", 1, 1'b1);
    chk("ack", bus_ack_octet, bus_b);
    chk("control", 8'h5a, host_octet);
    i_host.lines(1'b1, 1'b0, 1'b0);
    wt("strobe", 1, 1'b0);
    chk("drive", 8'h00, 8'(bus_b_oe));
    i_host.lines(1'b1, 1'b1, 1'b0);
    wt("phase", 0, 1'b0);
    i_host.put(8'hc3, 1'b0);
    i_host.lines(1'b1, 1'b0, 1'b0);
    wt("phase", 0, 1'b1);
    chk("status", slave_status_octet, bus_b);
    chk("status parity", 8'(~^slave_status_octet), 8'(bus_b_par));
    chk("master status", 8'hc3, host_octet);
    i_host.lines(1'b0, 1'b0, 1'b0);
    wt("selected", 3, 1'b0);
    $display("exchange test done");
  end
  endtask
  task automatic t_refusals;
  begin
    busy = 1'b1;
    i_host.put({5'h00, my_addr}, 1'b0);
    i_host.lines(1'b1, 1'b0, 1'b0);
    wt("phase", 0, 1'b1);
    chk("drive", 8'h00, 8'(bus_b_oe));
    i_host.lines(1'b0, 1'b0, 1'b0);
    busy = 1'b0;
    i_host.put({5'h00, my_addr}, 1'b1);
    i_host.lines(1'b1, 1'b0, 1'b0);
    repeat (10) @(negedge clk);
    chk("phase", 8'h00, 8'(slave_in));
    chk("selected", 8'h00, 8'(selected));
    i_host.lines(1'b0, 1'b0, 1'b0);
    i_host.put({5'h00, my_addr}, 1'b0);
    i_host.lines(1'b1, 1'b0, 1'b0);
    wt("phase", 0, 1'b1);
    i_host.lines(1'b1, 1'b1, 1'b0);
    wt("phase", 0, 1'b0);
    chk("strobe", 8'h00, 8'(sync_in));
    chk("released", 8'h00, 8'(bus_b_oe));
    i_host.lines(1'b0, 1'b0, 1'b0);
    $display("refusal test done");
  end
  endtask
  task automatic t_request;
    logic [7:0] exp;
  begin
    irq_pending = 1'b1;
    for (int c = 0; c < 3; c++)
    begin
      exp = (c == 0) ? 8'h01 << my_addr : (c == 1) ? settings_octet : fac_irq_octet;
      i_host.put({c[3:0], 1'b0, my_addr}, 1'b0);
      i_host.lines(1'b0, 1'b1, 1'b0);
      wt("drive", 2, 1'b1);
      chk("response", exp, bus_b);
      chk("parity", 8'(~^exp), 8'(bus_b_par));
      wt("phase", 0, c != 0);
      i_host.lines(1'b0, 1'b0, 1'b0);
      wt("drive", 2, 1'b0);
      wt("phase", 0, 1'b0);
    end
    // A poll with nothing pending and a query to another target stay silent.
    irq_pending = 1'b0;
    for (int c = 0; c < 2; c++)
    begin
      i_host.put({c[3:0], 1'b0, my_addr ^ {3{c[0]}}}, 1'b0);
      i_host.lines(1'b0, 1'b1, 1'b0);
      repeat (8) @(negedge clk);
      chk("ignored", 8'h00, 8'(obs[2:0]));
      i_host.lines(1'b0, 1'b0, 1'b0);
    end
    $display("request test done");
  end
  endtask
  task automatic t_resets;
    int n0;
  begin
    i_host.lines(1'b0, 1'b0, 1'b0);
    i_host.strobe(1'b0, 1'b0);
    chk("maintenance", 8'h01, 8'(maintenance_state_mode));
    n0 = n_pulse;
    i_host.sel_reset(my_addr);
    chk("reset pulses", 8'h01, 8'(n_pulse - n0));
    chk("maintenance", 8'h00, 8'(maintenance_state_mode));
    chk("phase", 8'h00, 8'(slave_in));
    $display("reset test done");
  end
  endtask
  initial
  begin
    {arst_n, busy, irq_pending} = 3'h0;
    my_addr = 3'h0;
    settings_octet = 8'h3c;
    fac_irq_octet = 8'h81;
    bus_ack_octet = 8'ha5;
    slave_status_octet = 8'h96;
    repeat (16) @(negedge clk);
    arst_n = 1'b1;
    t_exchange();
    my_addr = 3'h7;
    t_exchange();
    t_refusals();
    t_request();
    t_resets();
    wrap_up();
  end
endmodule
